// *** rtl/gpcap_regs.sv ***
// Register access over APB was decided locally.
`timescale 1ns/1ps
// How it works
// RL1 - Queue depth field reads constant 1Fh
// RL2 - Sideband support status bit reads one
// RL3 - Above 4 GB status bit reads zero
// RL4 - Fast write support bit reads one
// RL5 - Rate capability field reads 111
// RL6 - Selected rate drives data, sideband, fast write; fast write rate is 1x while fast write is off
// RL7 - Sideband mechanism active only when enabled
// RL8 - Port disabled ignores all operations, sync too
// RL9 - Accepted operations complete after enable clears
// RL10 - Partial 1x sideband command still issues
// RL11 - Pipe always, sideband only when enabled
// RL12 - Fast write enable uses fast protocol
// RL13 - Fall back to PCI when off or 1x
// RL14 - Software selects exactly one rate bit
// RL15 - Reserved bits read zero, writes ignored
module gpcap_regs (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic PIPE_REQ_I,
  input wire logic SIDEBAND_REQ_I,
  input wire logic SYNC_REQ_I,
  input wire logic OP_DONE_I,
  output logic PIPE_ACCEPT_O,
  output logic SIDEBAND_ACCEPT_O,
  output logic SIDEBAND_ISSUE_O,
  output logic SYNC_ACCEPT_O,
  output logic OP_PENDING_O,
  output logic FAST_WRITE_O,
  output logic [2:0] DATA_RATE_O,
  output logic [2:0] SIDEBAND_RATE_O,
  output logic [2:0] FAST_WRITE_RATE_O,
  output logic RATE_ERROR_O
);
  // ==========================================================
  // Register slave
  logic [31:0] command_w;
  logic [31:0] prdata_w;
  logic pready_w;
  logic pslverr_w;
  gpcap_pkg::gpcap_ctrl_t ctrl;

  gpcap_apb_slave u_apb (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .pwdata_i(PWDATA_I),
    .prdata_o(prdata_w),
    .pready_o(pready_w),
    .pslverr_o(pslverr_w),
    .command_o(command_w)
  );

  // Bus answers come registered from the slave, one wait state
  assign PRDATA_O = prdata_w;
  assign PREADY_O = pready_w;
  assign PSLVERR_O = pslverr_w;

  // Decode command fields into the carrier struct
  assign ctrl = {command_w[gpcap_pkg::CMD_PORT_EN_BIT], command_w[gpcap_pkg::CMD_SIDEBAND_BIT],
                 command_w[gpcap_pkg::CMD_FAST_WRITE_BIT], command_w[2:0]};

  // ==========================================================
  // Request gating
  logic pipe_ok;
  logic sb_ok;
  logic sync_ok;
  logic sb_busy;
  logic sb_issue;
  logic one_x;

  assign one_x = ctrl.transfer_rate_select == gpcap_pkg::RATE_1X;
  assign pipe_ok = ctrl.port_enable && PIPE_REQ_I; // RL8 RL11
  assign sb_ok = ctrl.port_enable && ctrl.sideband_enable && SIDEBAND_REQ_I; // RL7 RL11
  assign sync_ok = ctrl.port_enable && SYNC_REQ_I; // RL8

  gpcap_sideband u_sb (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .accept_i(ctrl.port_enable && ctrl.sideband_enable),
    .start_i(SIDEBAND_REQ_I),
    .one_x_i(one_x),
    .issue_o(sb_issue),
    .busy_o(sb_busy)
  );

  // Accept strobes, one cycle each
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PIPE_ACCEPT_O <= 1'b0;
      SIDEBAND_ACCEPT_O <= 1'b0;
      SYNC_ACCEPT_O <= 1'b0;
      SIDEBAND_ISSUE_O <= 1'b0;
    end else begin
      PIPE_ACCEPT_O <= pipe_ok;
      SIDEBAND_ACCEPT_O <= sb_ok && !sb_busy;
      SYNC_ACCEPT_O <= sync_ok;
      SIDEBAND_ISSUE_O <= sb_issue; // RL10
    end
  end

  // ==========================================================
  // Outstanding operations; a count survives enable falling so
  // accepted work still completes. Saturates at 20h, one above the 1Fh queue depth.
  logic [5:0] pending_q;
  logic take;
  assign take = pipe_ok || (sb_ok && !sb_busy);

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pending_q <= 6'h00;
    end else if (take && !OP_DONE_I && pending_q != 6'h20) begin
      pending_q <= pending_q + 6'h01;
    end else if (!take && OP_DONE_I && pending_q != 6'h00) begin
      pending_q <= pending_q - 6'h01; // RL9
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      OP_PENDING_O <= 1'b0;
    end else begin
      OP_PENDING_O <= pending_q != 6'h00; // RL9
    end
  end

  // ==========================================================
  // Rate and write protocol selection
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DATA_RATE_O <= 3'h0;
      SIDEBAND_RATE_O <= 3'h0;
      FAST_WRITE_RATE_O <= 3'h0;
      FAST_WRITE_O <= 1'b0;
    end else begin
      DATA_RATE_O <= ctrl.transfer_rate_select; // RL6
      SIDEBAND_RATE_O <= ctrl.transfer_rate_select; // RL6
      FAST_WRITE_RATE_O <= ctrl.fast_write_enable ? ctrl.transfer_rate_select : gpcap_pkg::RATE_1X; // RL6
      FAST_WRITE_O <= ctrl.fast_write_enable && !one_x; // RL12 RL13
    end
  end

  // Flag a rate field that is not one-hot while the port runs
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RATE_ERROR_O <= 1'b0;
    end else begin
      RATE_ERROR_O <= ctrl.port_enable && !$onehot(ctrl.transfer_rate_select); // RL14
    end
  end

  // ==========================================================
  // Checks
  chk_port_off_idle: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL8
    !ctrl.port_enable |=> !PIPE_ACCEPT_O && !SYNC_ACCEPT_O) else $error("accepted while disabled");
  chk_sb_gated: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL7
    !ctrl.sideband_enable |=> !SIDEBAND_ACCEPT_O) else $error("sideband accepted while off");
  chk_pipe_accept: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL11
    (ctrl.port_enable && PIPE_REQ_I) |=> PIPE_ACCEPT_O) else $error("pipe request dropped");
  chk_fw_onex: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL13
    one_x |=> !FAST_WRITE_O || $past(ctrl.transfer_rate_select) != gpcap_pkg::RATE_1X)
    else $error("fast write in 1x");
  chk_fw_enable: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL12
    (ctrl.fast_write_enable && ctrl.transfer_rate_select == gpcap_pkg::RATE_4X) |=> FAST_WRITE_O)
    else $error("fast write not used");
  chk_rate_same: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL6
    1'b1 |=> DATA_RATE_O == $past(ctrl.transfer_rate_select) && SIDEBAND_RATE_O == DATA_RATE_O)
    else $error("rates differ");
  chk_pending_keep: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL9
    (pending_q != 6'h00 && !OP_DONE_I) |=> pending_q != 6'h00) else $error("pending lost");
  chk_queue_field: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL1 RL2 RL3 RL4 RL5
    (PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && PADDR_I == gpcap_pkg::STATUS_OFFSET)
    |-> PRDATA_O[31:24] == 8'h1F && PRDATA_O[9] && !PRDATA_O[5] && PRDATA_O[4] && PRDATA_O[2:0] == 3'h7)
    else $error("status fields wrong");
  chk_cmd_reserved: assert property (@(posedge CLK_I) disable iff (!RST_B_I) // RL15
    (PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && PADDR_I == gpcap_pkg::COMMAND_OFFSET)
    |-> PRDATA_O[31:10] == 22'h00_0000 && PRDATA_O[7:5] == 3'h0 && !PRDATA_O[3])
    else $error("reserved bits nonzero");

  cov_pipe: cover property (@(posedge CLK_I) disable iff (!RST_B_I) PIPE_ACCEPT_O);
  cov_sb_issue: cover property (@(posedge CLK_I) disable iff (!RST_B_I) SIDEBAND_ISSUE_O);
  cov_fw: cover property (@(posedge CLK_I) disable iff (!RST_B_I) FAST_WRITE_O);
  cov_sb_drop_en: cover property (@(posedge CLK_I) disable iff (!RST_B_I) sb_busy && !ctrl.port_enable);

endmodule : gpcap_regs

// *** rtl/gpcap_pkg.sv ***
package gpcap_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] STATUS_OFFSET = 8'h00_A4;
  localparam logic [7:0] COMMAND_OFFSET = 8'h00_A8;
  localparam logic [31:0] STATUS_RESET = 32'h1F00_0217;
  localparam logic [31:0] COMMAND_RESET = 32'h0000_0000;

  // ==========================================================
  // Status field layout
  localparam int STAT_QUEUE_LSB = 24;
  localparam logic [7:0] STAT_QUEUE_DEPTH = 8'h1F;
  localparam int STAT_SIDEBAND_BIT = 9;
  localparam int STAT_ABOVE4G_BIT = 5;
  localparam int STAT_FAST_WRITE_BIT = 4;
  localparam logic [2:0] STAT_RATE_SUPPORT = 3'h7;

  // ==========================================================
  // Command field layout
  localparam int CMD_SIDEBAND_BIT = 9;
  localparam int CMD_PORT_EN_BIT = 8;
  localparam int CMD_FAST_WRITE_BIT = 4;
  localparam logic [31:0] CMD_WRITE_MASK = 32'h0000_0317;

  // One-hot transfer rate codes
  localparam logic [2:0] RATE_1X = 3'h1;
  localparam logic [2:0] RATE_2X = 3'h2;
  localparam logic [2:0] RATE_4X = 3'h4;

  // Sideband command length in 1x mode (clocks)
  localparam logic [1:0] SB_1X_BEATS = 2'h2;

  // Control carried to the port engine
  typedef struct packed {
    logic port_enable;
    logic sideband_enable;
    logic fast_write_enable;
    logic [2:0] transfer_rate_select;
  } gpcap_ctrl_t;

  typedef enum logic [1:0] {
    SB_IDLE = 2'b00,
    SB_COLLECT = 2'b01,
    SB_ISSUE = 2'b10
  } gpcap_sb_state_t;

endpackage : gpcap_pkg

// *** rtl/gpcap_apb_slave.sv ***
`timescale 1ns/1ps
// ==========================================================
// APB register slave: status read only, command read/write
module gpcap_apb_slave (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] command_o
);
  logic [31:0] command_q;
  logic [31:0] status_w;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic hit_cmd;
  logic hit_stat;
  logic access_w;
  logic done_w;

  // Hardwired capability word, reserved bits zero
  assign status_w = {gpcap_pkg::STAT_QUEUE_DEPTH, 14'h0000, 1'b1, 3'h0, 1'b0, 1'b1, 1'b0,
                     gpcap_pkg::STAT_RATE_SUPPORT}; // RL1 RL2 RL3 RL4 RL5 RL15
  assign hit_cmd = paddr_i == gpcap_pkg::COMMAND_OFFSET;
  assign hit_stat = paddr_i == gpcap_pkg::STATUS_OFFSET;
  assign access_w = psel_i && penable_i && !pready_q;
  assign done_w = psel_i && penable_i && pready_q;
  assign pready_o = pready_q;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q;
  assign command_o = command_q;

  // Command write on the completing edge; masked so reserved bits never store
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      command_q <= gpcap_pkg::COMMAND_RESET;
    end else if (done_w && pwrite_i && hit_cmd) begin
      command_q <= pwdata_i & gpcap_pkg::CMD_WRITE_MASK; // RL15
    end
  end

  // Answer registered, one wait state, so bus outputs come from flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access_w;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      if (access_w) begin
        if (hit_stat && !pwrite_i) begin
          prdata_q <= status_w;
        end else if (hit_cmd && !pwrite_i) begin
          prdata_q <= command_q;
        end
        pslverr_q <= !(hit_stat || hit_cmd); // Status writes ignored quietly
      end
    end
  end

  chk_status_const: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL1
    (done_w && !pwrite_i && hit_stat) |-> prdata_o == gpcap_pkg::STATUS_RESET) else $error("status word wrong");
  chk_cmd_reserved: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL15
    (command_q & ~gpcap_pkg::CMD_WRITE_MASK) == 32'h0000_0000) else $error("reserved command bit set");
  cov_cmd_write: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    done_w && pwrite_i && hit_cmd);

endmodule : gpcap_apb_slave

// *** rtl/gpcap_sideband.sv ***
`timescale 1ns/1ps
// ==========================================================
// Sideband command collector; finishes a started 1x command
module gpcap_sideband (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic accept_i,
  input wire logic start_i,
  input wire logic one_x_i,
  output logic issue_o,
  output logic busy_o
);
  gpcap_pkg::gpcap_sb_state_t state_q;
  logic [1:0] beat_q;

  // Busy until issued, so an accepted start is never dropped
  assign busy_o = state_q != gpcap_pkg::SB_IDLE;

  // Once begun, the command runs to issue regardless of enable
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= gpcap_pkg::SB_IDLE;
      beat_q <= 2'h0;
    end else begin
      case (state_q)
        gpcap_pkg::SB_IDLE: begin
          if (start_i && accept_i) begin
            state_q <= one_x_i ? gpcap_pkg::SB_COLLECT : gpcap_pkg::SB_ISSUE;
            beat_q <= 2'h1;
          end
        end
        gpcap_pkg::SB_COLLECT: begin
          beat_q <= beat_q + 2'h1;
          if (beat_q + 2'h1 == gpcap_pkg::SB_1X_BEATS) begin
            state_q <= gpcap_pkg::SB_ISSUE; // RL10
          end
        end
        gpcap_pkg::SB_ISSUE: begin
          state_q <= gpcap_pkg::SB_IDLE;
        end
        default: begin
          state_q <= gpcap_pkg::SB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      issue_o <= 1'b0;
    end else begin
      issue_o <= state_q == gpcap_pkg::SB_ISSUE;
    end
  end

  chk_sb_finish: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL10
    (state_q == gpcap_pkg::SB_COLLECT) |-> ##[1:2] (state_q == gpcap_pkg::SB_ISSUE))
    else $error("sideband command not issued");

endmodule : gpcap_sideband

// *** verification/gpcap_master_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Graphics master model: one-cycle request pulses
module gpcap_master_model (
  input wire logic clk_i,
  output logic pipe_req_o,
  output logic sideband_req_o,
  output logic sync_req_o,
  output logic op_done_o
);
  logic [3:0] req_q;

  // Start idle before the first edge
  initial begin
    req_q <= 4'h0;
  end

  // Lines idle low between pulses, like a released request
  assign {op_done_o, sync_req_o, sideband_req_o, pipe_req_o} = req_q;

  // Kind 0 pipe, 1 sideband start, 2 sync, 3 done
  task automatic fire(input int unsigned kind);
    @(posedge clk_i);
    req_q <= 4'h1 << kind;
    @(posedge clk_i);
    req_q <= 4'h0;
  endtask : fire
endmodule : gpcap_master_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps
// ==========================================================
// Register bank bench: APB accesses plus port engine pulses
module testbench;
  logic CLK_I;
  logic RST_B_I;
  logic PSEL_I;
  logic PENABLE_I;
  logic PWRITE_I;
  logic [7:0] PADDR_I;
  logic [31:0] PWDATA_I;
  logic [31:0] PRDATA_O;
  logic PREADY_O, PSLVERR_O, PIPE_ACCEPT_O, SIDEBAND_ACCEPT_O, SIDEBAND_ISSUE_O, SYNC_ACCEPT_O;
  logic OP_PENDING_O, FAST_WRITE_O, RATE_ERROR_O;
  logic [2:0] DATA_RATE_O, SIDEBAND_RATE_O, FAST_WRITE_RATE_O;
  wire logic PIPE_REQ_I, SIDEBAND_REQ_I, SYNC_REQ_I, OP_DONE_I;
  int fails = 0;
  int checks = 0;
  int n_acc = 0;
  int n_iss = 0;
  logic [2:0] r;

  gpcap_regs dut_u (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PIPE_REQ_I(PIPE_REQ_I), .SIDEBAND_REQ_I(SIDEBAND_REQ_I),
    .SYNC_REQ_I(SYNC_REQ_I), .OP_DONE_I(OP_DONE_I), .PIPE_ACCEPT_O(PIPE_ACCEPT_O),
    .SIDEBAND_ACCEPT_O(SIDEBAND_ACCEPT_O), .SIDEBAND_ISSUE_O(SIDEBAND_ISSUE_O), .SYNC_ACCEPT_O(SYNC_ACCEPT_O),
    .OP_PENDING_O(OP_PENDING_O), .FAST_WRITE_O(FAST_WRITE_O), .DATA_RATE_O(DATA_RATE_O),
    .SIDEBAND_RATE_O(SIDEBAND_RATE_O), .FAST_WRITE_RATE_O(FAST_WRITE_RATE_O), .RATE_ERROR_O(RATE_ERROR_O));

  gpcap_master_model mdl_u (.clk_i(CLK_I), .pipe_req_o(PIPE_REQ_I), .sideband_req_o(SIDEBAND_REQ_I),
    .sync_req_o(SYNC_REQ_I), .op_done_o(OP_DONE_I));

  // ==========================================================
  // Clock, pulse counters, watchdog
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end

  // Sampled on the falling edge so registered pulses have settled
  always @(negedge CLK_I) begin
    if (PIPE_ACCEPT_O === 1'b1) n_acc++;
    if (SIDEBAND_ACCEPT_O === 1'b1) n_acc++;
    if (SYNC_ACCEPT_O === 1'b1) n_acc++;
    if (SIDEBAND_ISSUE_O === 1'b1) n_iss++;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #40000;
    fails++;
    end_of_test();
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= wr;
    PADDR_I <= a;
    PWDATA_I <= wd;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    @(posedge CLK_I);
    // Only the watchdog ends a wait that never completes
    while (PREADY_O !== 1'b1) begin
      @(posedge CLK_I);
    end
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask : rd_chk

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Test sequence
  initial begin
    RST_B_I <= 1'b0;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    PWRITE_I <= 1'b0;
    PADDR_I <= 8'h00;
    PWDATA_I <= 32'h0000_0000;
    repeat (4) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    rd_chk(gpcap_pkg::STATUS_OFFSET, 32'h1F00_0217, 1'b0);
    rd_chk(gpcap_pkg::COMMAND_OFFSET, 32'h0000_0000, 1'b0);
    wr(gpcap_pkg::STATUS_OFFSET, 32'h0000_0000);
    rd_chk(gpcap_pkg::STATUS_OFFSET, 32'h1F00_0217, 1'b0);
    wr(gpcap_pkg::COMMAND_OFFSET, 32'hFFFF_FCE8);
    rd_chk(gpcap_pkg::COMMAND_OFFSET, 32'h0000_0000, 1'b0);
    rd_chk(8'h40, 32'h0000_0000, 1'b1);
    // Port disabled: pipe, sync and sideband all ignored
    mdl_u.fire(0);
    mdl_u.fire(2);
    mdl_u.fire(1);
    repeat (3) @(negedge CLK_I);
    chk(n_acc, 0);
    // Port on, sideband off; one-hot 1x select from software
    wr(gpcap_pkg::COMMAND_OFFSET, 32'h0000_0101);
    mdl_u.fire(0);
    repeat (2) @(negedge CLK_I);
    chk(n_acc, 1);
    mdl_u.fire(1);
    repeat (2) @(negedge CLK_I);
    chk(n_acc, 1);
    mdl_u.fire(2);
    repeat (2) @(negedge CLK_I);
    chk(n_acc, 2);
    // Sideband start lands on the edge where the port enable drops
    wr(gpcap_pkg::COMMAND_OFFSET, 32'h0000_0301);
    fork
      wr(gpcap_pkg::COMMAND_OFFSET, 32'h0000_0001);
      begin
        // Start sampled on the write's completing edge
        repeat (2) @(posedge CLK_I);
        mdl_u.fire(1);
      end
    join
    repeat (5) @(negedge CLK_I);
    chk(n_acc, 3);
    chk(n_iss, 1);
    chk({31'h0, OP_PENDING_O}, 32'h0000_0001);
    // Two operations outstanding: one done leaves one pending
    mdl_u.fire(3);
    repeat (2) @(negedge CLK_I);
    chk({31'h0, OP_PENDING_O}, 32'h0000_0001);
    mdl_u.fire(3);
    repeat (2) @(negedge CLK_I);
    chk({31'h0, OP_PENDING_O}, 32'h0000_0000);
    // Fast write enabled at each one-hot rate; FAST_WRITE_O stays off at 1x
    for (int i = 0; i < 3; i++) begin
      r = 3'h1 << i;
      wr(gpcap_pkg::COMMAND_OFFSET, 32'h0000_0110 | {29'h0, r});
      repeat (2) @(negedge CLK_I);
      chk({31'h0, FAST_WRITE_O}, (i != 0) ? 32'h0000_0001 : 32'h0000_0000);
      chk({29'h0, FAST_WRITE_RATE_O}, {29'h0, r});
      chk({29'h0, DATA_RATE_O}, {29'h0, r});
      chk({29'h0, SIDEBAND_RATE_O}, {29'h0, r});
      chk({31'h0, RATE_ERROR_O}, 32'h0000_0000);
    end
    wr(gpcap_pkg::COMMAND_OFFSET, 32'h0000_0104);
    repeat (2) @(negedge CLK_I);
    chk({31'h0, FAST_WRITE_O}, 32'h0000_0000);
    chk({29'h0, FAST_WRITE_RATE_O}, {29'h0, gpcap_pkg::RATE_1X});
    chk({29'h0, DATA_RATE_O}, {29'h0, gpcap_pkg::RATE_4X});
    rd_chk(gpcap_pkg::COMMAND_OFFSET, 32'h0000_0104, 1'b0);
    end_of_test();
  end
endmodule : testbench
